// ---- rtl/lpst_top.sv ----
// Sync output timing, multiframe period readback and per-lane PRBS test registers
`include "lpst_params.svh"

module lpst_top #(
	parameter int LANES        = 8,
	parameter int DATA_W       = 32,
	parameter int FRAME_OCTETS = 1
) (
	input  wire logic                    i_mclk,
	input  wire logic                    i_rst,
	input  wire logic [11:0]             i_reg_addr,
	input  wire logic                    i_reg_wr,
	input  wire logic                    i_reg_rd,
	input  wire logic [7:0]              i_reg_wdata,
	output logic      [7:0]              o_reg_rdata,
	output logic                         o_reg_rvalid,
	input  wire logic                    i_sync_request,
	input  wire logic                    i_sync_error,
	input  wire logic                    i_lmfc_pulse,
	input  wire logic [LANES*DATA_W-1:0] i_lane_data,
	input  wire logic [LANES-1:0]        i_lane_valid,
	output logic                         o_sync_request_out_n
);

	// Request base length in parallel cycles, rounded up
	localparam int REQ_OCTETS = `LPST_REQ_FRAMES * FRAME_OCTETS + `LPST_REQ_OCTETS;
	localparam int REQ_BASE   = (REQ_OCTETS + `LPST_OCTETS_PER_PCLK - 1) / `LPST_OCTETS_PER_PCLK;
	localparam logic [7:0] REQ_BASE_8 = 8'(REQ_BASE);

	lpst_pkg::lpst_top_state_t s_reg;
	lpst_pkg::lpst_top_state_t s_next;
	logic [23:0]               lane_cnt [LANES];
	logic [7:0]                pass_bits;
	logic [23:0]               sel_cnt;

	// ----------------------------------------
	// Lane checkers
	// ----------------------------------------
	generate
		for (genvar l = 0; l < 8; l++)
		begin : g_lane
			if (l < LANES)
			begin : g_on
				lpst_lane_if lif ();
				assign lif.enable    = s_reg.test_en[l];
				assign lif.run       = s_reg.run;
				assign lif.clear     = s_reg.clr;
				assign lif.pattern   = s_reg.pat;
				assign lif.threshold = s_reg.thr;
				assign lane_cnt[l]   = lif.count;
				assign pass_bits[l]  = lif.pass;
				lpst_lane_checker #(.DATA_W(DATA_W)) u_chk (
					.i_mclk  (i_mclk),
					.i_rst   (i_rst),
					.i_data  (i_lane_data[l*DATA_W +: DATA_W]),
					.i_valid (i_lane_valid[l]),
					.ctl     (lif.chk)
				);
			end
			else
			begin : g_off
				assign pass_bits[l] = 1'b1;
			end
		end
	endgenerate

	always_comb
	begin
		sel_cnt = 24'h000000;
		for (int l = 0; l < LANES; l++)
			if (s_reg.cnt_sel == 3'(l))
				sel_cnt = lane_cnt[l];
	end

	// Read mux by address
	function automatic logic [7:0] read_byte(input logic [11:0] a, input lpst_pkg::lpst_top_state_t s,
		input logic [23:0] c, input logic [7:0] p);
		logic [7:0] r;
		r = 8'h00;
		if (a == `LPST_OFF_SYNC_DUR)
			r = s.sync_dur;
		else if (a == `LPST_OFF_LMFC_PER)
			r = s.lmfc_per;
		else if (a == `LPST_OFF_TEST_EN)
			r = s.test_en;
		else if (a == `LPST_OFF_TEST_CTRL)
			r = {1'b0, s.cnt_sel, s.pat, s.run, s.clr};
		else if (a == `LPST_OFF_THR_LOW)
			r = s.thr[7:0];
		else if (a == `LPST_OFF_THR_MID)
			r = s.thr[15:8];
		else if (a == `LPST_OFF_THR_HIGH)
			r = s.thr[23:16];
		else if (a == `LPST_OFF_CNT_LOW)
			r = c[7:0];
		else if (a == `LPST_OFF_CNT_MID)
			r = c[15:8];
		else if (a == `LPST_OFF_CNT_HIGH)
			r = c[23:16];
		else if (a == `LPST_OFF_PASS)
			r = p;
		return r;
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		s_next        = s_reg;
		s_next.rvalid = i_reg_rd;
		if (i_reg_rd)
			s_next.rdata = read_byte(i_reg_addr, s_reg, sel_cnt, pass_bits);

		// Register writes
		if (i_reg_wr)
		begin
			if (i_reg_addr == `LPST_OFF_SYNC_DUR)
				s_next.sync_dur = i_reg_wdata;
			else if (i_reg_addr == `LPST_OFF_TEST_EN)
				s_next.test_en = i_reg_wdata;
			else if (i_reg_addr == `LPST_OFF_TEST_CTRL)
			begin
				s_next.cnt_sel = i_reg_wdata[`LPST_CNT_SEL_MSB:`LPST_CNT_SEL_LSB];
				s_next.pat = lpst_pkg::lpst_pattern_t'(i_reg_wdata[`LPST_PAT_MSB:`LPST_PAT_LSB]);
				s_next.run = i_reg_wdata[`LPST_RUN_BIT];
				s_next.clr = i_reg_wdata[`LPST_CLR_BIT];
			end
			else if (i_reg_addr == `LPST_OFF_THR_LOW)
				s_next.thr[7:0] = i_reg_wdata;
			else if (i_reg_addr == `LPST_OFF_THR_MID)
				s_next.thr[15:8] = i_reg_wdata;
			else if (i_reg_addr == `LPST_OFF_THR_HIGH)
				s_next.thr[23:16] = i_reg_wdata;
		end

		if (i_lmfc_pulse)
		begin
			s_next.lmfc_per = s_reg.lmfc_cnt + 8'h01;
			s_next.lmfc_cnt = 8'h00;
		end
		else if (s_reg.lmfc_cnt != 8'hff)
			s_next.lmfc_cnt = s_reg.lmfc_cnt + 8'h01;

		// Sync output sequencer
		case (s_reg.st)
			lpst_pkg::LPST_SYNC_IDLE:
			begin
				if (i_sync_request)
				begin
					s_next.st       = lpst_pkg::LPST_SYNC_REQ;
					s_next.sync_cnt = REQ_BASE_8 - 8'h01
						+ {4'h0, s_reg.sync_dur[`LPST_REQ_DUR_MSB:`LPST_REQ_DUR_LSB]};
				end
				else if (i_sync_error)
				begin
					s_next.st       = lpst_pkg::LPST_SYNC_ERR;
					s_next.sync_cnt = {4'h0, s_reg.sync_dur[`LPST_ERR_DUR_MSB:`LPST_ERR_DUR_LSB]};
				end
			end
			lpst_pkg::LPST_SYNC_REQ:
			begin
				if (s_reg.sync_cnt != 8'h00)
					s_next.sync_cnt = s_reg.sync_cnt - 8'h01;
				else if (!i_sync_request)
					s_next.st = lpst_pkg::LPST_SYNC_IDLE;
			end
			lpst_pkg::LPST_SYNC_ERR:
			begin
				if (s_reg.sync_cnt != 8'h00)
					s_next.sync_cnt = s_reg.sync_cnt - 8'h01;
				else
					s_next.st = lpst_pkg::LPST_SYNC_IDLE;
			end
			default:
				s_next.st = lpst_pkg::LPST_SYNC_IDLE;
		endcase
		s_next.sync_n = (s_next.st == lpst_pkg::LPST_SYNC_IDLE);
	end

	// State register
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			s_reg          <= '0;
			s_reg.st       <= lpst_pkg::LPST_SYNC_IDLE;
			s_reg.sync_n   <= 1'b1;
			s_reg.sync_dur <= `LPST_RST_BYTE;
			s_reg.test_en  <= `LPST_RST_BYTE;
			s_reg.thr      <= `LPST_RST_THR;
		end
		else
			s_reg <= s_next;
	end

	assign o_reg_rdata          = s_reg.rdata;
	assign o_reg_rvalid         = s_reg.rvalid;
	assign o_sync_request_out_n = s_reg.sync_n;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_err_start;
		s_reg.st == lpst_pkg::LPST_SYNC_IDLE && !i_sync_request && i_sync_error
			&& s_reg.sync_dur[7:4] == 4'h0;
	endsequence
	sequence s_one_low;
		!o_sync_request_out_n ##1 o_sync_request_out_n;
	endsequence

	a_err_one_cycle: assert property (@(posedge i_mclk) disable iff (i_rst)
		s_err_start |=> s_one_low)
		else $error("error report low time wrong");
	a_req_goes_low: assert property (@(posedge i_mclk) disable iff (i_rst)
		s_reg.st == lpst_pkg::LPST_SYNC_IDLE && i_sync_request |=> !o_sync_request_out_n [*2])
		else $error("sync request not held low");
	a_lmfc_capture: assert property (@(posedge i_mclk) disable iff (i_rst)
		i_lmfc_pulse |=> s_reg.lmfc_per == $past(s_reg.lmfc_cnt) + 8'h01)
		else $error("multiframe period not captured");
	a_pass_read: assert property (@(posedge i_mclk) disable iff (i_rst)
		i_reg_rd && i_reg_addr == `LPST_OFF_PASS |=> o_reg_rvalid && o_reg_rdata == $past(pass_bits))
		else $error("pass flags read wrong");
	a_cnt_high_read: assert property (@(posedge i_mclk) disable iff (i_rst)
		i_reg_rd && i_reg_addr == `LPST_OFF_CNT_HIGH |=> o_reg_rdata == $past(sel_cnt[23:16]))
		else $error("high count byte wrong");
	a_thr_write: assert property (@(posedge i_mclk) disable iff (i_rst)
		i_reg_wr && i_reg_addr == `LPST_OFF_THR_MID |=> s_reg.thr[15:8] == $past(i_reg_wdata))
		else $error("threshold mid byte not stored");

endmodule // lpst_top

// ---- rtl/lpst_params.svh ----
// Register offsets, field positions, reset values and timing counts of the lane test block
`ifndef LPST_PARAMS_SVH
`define LPST_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LPST_OFF_SYNC_DUR    12'h312
`define LPST_OFF_LMFC_PER    12'h313
`define LPST_OFF_TEST_EN     12'h315
`define LPST_OFF_TEST_CTRL   12'h316
`define LPST_OFF_THR_LOW     12'h317
`define LPST_OFF_THR_MID     12'h318
`define LPST_OFF_THR_HIGH    12'h319
`define LPST_OFF_CNT_LOW     12'h31a
`define LPST_OFF_CNT_MID     12'h31b
`define LPST_OFF_CNT_HIGH    12'h31c
`define LPST_OFF_PASS        12'h31d

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LPST_ERR_DUR_MSB     7
`define LPST_ERR_DUR_LSB     4
`define LPST_REQ_DUR_MSB     3
`define LPST_REQ_DUR_LSB     0
`define LPST_CNT_SEL_MSB     6
`define LPST_CNT_SEL_LSB     4
`define LPST_PAT_MSB         3
`define LPST_PAT_LSB         2
`define LPST_RUN_BIT         1
`define LPST_CLR_BIT         0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LPST_RST_BYTE        8'h00
`define LPST_RST_THR         24'h000000
`define LPST_RST_PASS        8'hff

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define LPST_CLK_PERIOD_NS   10
`define LPST_OCTETS_PER_PCLK 4
`define LPST_REQ_FRAMES      5
`define LPST_REQ_OCTETS      9
`define LPST_CNT_MAX         24'hffffff

`endif

// ---- rtl/lpst_pkg.sv ----
// Types shared by the lane test block
package lpst_pkg;

	// Sync output sequencer states
	typedef enum logic [1:0]
	{
		LPST_SYNC_IDLE = 2'b00,
		LPST_SYNC_REQ  = 2'b01,
		LPST_SYNC_ERR  = 2'b10
	} lpst_sync_state_t;

	// Checked pattern codes
	typedef enum logic [1:0]
	{
		LPST_PRBS7  = 2'b00,
		LPST_PRBS15 = 2'b01,
		LPST_PRBS31 = 2'b10,
		LPST_PRBSX  = 2'b11
	} lpst_pattern_t;

	// State of the top module
	typedef struct packed
	{
		lpst_sync_state_t st;
		logic [7:0]       sync_cnt;
		logic             sync_n;
		logic [7:0]       sync_dur;
		logic [7:0]       test_en;
		logic [2:0]       cnt_sel;
		lpst_pattern_t    pat;
		logic             run;
		logic             clr;
		logic [23:0]      thr;
		logic [7:0]       lmfc_cnt;
		logic [7:0]       lmfc_per;
		logic [7:0]       rdata;
		logic             rvalid;
	} lpst_top_state_t;

	// State of one lane checker
	typedef struct packed
	{
		logic [30:0] hist;
		logic        primed;
		logic [23:0] cnt;
		logic        pass;
	} lpst_chk_state_t;

endpackage

// ---- rtl/lpst_lane_if.sv ----
// Control and result signals between the top and one lane checker
interface lpst_lane_if;
	logic                  enable;
	logic                  run;
	logic                  clear;
	lpst_pkg::lpst_pattern_t pattern;
	logic [23:0]           threshold;
	logic [23:0]           count;
	logic                  pass;

	modport ctrl (output enable, output run, output clear, output pattern, output threshold,
		input count, input pass);
	modport chk  (input enable, input run, input clear, input pattern, input threshold,
		output count, output pass);
endinterface

// ---- rtl/lpst_lane_checker.sv ----
// Self-synchronising PRBS error checker for one lane
`include "lpst_params.svh"

module lpst_lane_checker #(
	parameter int DATA_W = 32
) (
	input  wire logic              i_mclk,
	input  wire logic              i_rst,
	input  wire logic [DATA_W-1:0] i_data,
	input  wire logic              i_valid,
	lpst_lane_if.chk               ctl
);

	lpst_pkg::lpst_chk_state_t s_reg;
	lpst_pkg::lpst_chk_state_t s_next;
	logic                      active;
	logic [30:0]               h;
	logic                      pred;
	logic [6:0]                errs;
	logic [24:0]               sum;

	assign active = ctl.enable && ctl.run && !ctl.clear;

	// Next state: predict each bit from history, count mismatches
	always_comb
	begin
		s_next = s_reg;
		h      = s_reg.hist;
		errs   = 7'h00;
		pred   = 1'b0;
		sum    = 25'h0000000;
		for (int b = 0; b < DATA_W; b++)
		begin
			case (ctl.pattern)
				lpst_pkg::LPST_PRBS7:  pred = h[6] ^ h[5];
				lpst_pkg::LPST_PRBS15: pred = h[14] ^ h[13];
				default:               pred = h[30] ^ h[27];
			endcase
			if (pred != i_data[b])
				errs = errs + 7'h01;
			h = {h[29:0], i_data[b]};
		end
		sum = {1'b0, s_reg.cnt} + {18'h00000, errs};
		if (ctl.clear)
		begin
			s_next.hist   = 31'h00000000;
			s_next.primed = 1'b0;
			s_next.cnt    = 24'h000000;
			s_next.pass   = 1'b1;
		end
		else if (active && i_valid)
		begin
			s_next.hist   = h;
			s_next.primed = 1'b1;
			if (s_reg.primed)
				s_next.cnt = sum[24] ? `LPST_CNT_MAX : sum[23:0];
		end
		if (!ctl.clear && s_next.cnt > ctl.threshold)
			s_next.pass = 1'b0;
	end

	// State register
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
			s_reg <= '{hist: 31'h00000000, primed: 1'b0, cnt: 24'h000000, pass: 1'b1};
		else
			s_reg <= s_next;
	end

	assign ctl.count = s_reg.cnt;
	assign ctl.pass  = s_reg.pass;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_count_saturates: assert property (@(posedge i_mclk) disable iff (i_rst)
		s_reg.cnt == `LPST_CNT_MAX && !ctl.clear |=> s_reg.cnt == `LPST_CNT_MAX)
		else $error("error count left saturation");
	a_gated_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
		!ctl.enable && !ctl.clear |=> $stable(s_reg.cnt))
		else $error("count moved while lane disabled");
	a_clear_zeroes: assert property (@(posedge i_mclk) disable iff (i_rst)
		ctl.clear |=> s_reg.cnt == 24'h000000 && s_reg.pass)
		else $error("clear did not zero lane");
	a_pass_fails: assert property (@(posedge i_mclk) disable iff (i_rst)
		s_reg.cnt > ctl.threshold && !ctl.clear |=> !s_reg.pass)
		else $error("pass kept above threshold");

endmodule // lpst_lane_checker

// ---- verification/lpst_prbs_source.sv ----
// Transmitter model sending the same PRBS word on every lane
module lpst_prbs_source #(
	parameter int LANES = 8
) (
	input  wire logic                i_mclk,
	input  wire logic                i_send,
	input  wire logic [1:0]          i_pattern,
	input  wire logic [LANES-1:0]    i_err_lane,
	output logic      [LANES*32-1:0] o_lane_data,
	output logic      [LANES-1:0]    o_lane_valid
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [30:0] hist = 31'h7fffffff; // Seeded history, never all zero
	logic [31:0] word;
	int          tap_a;
	int          tap_b;

	// Feedback taps of the chosen sequence; code 3 runs the longest one
	always_comb
	begin
		tap_a = (i_pattern == 2'h0) ? 7 : (i_pattern == 2'h1) ? 15 : 31;
		tap_b = (i_pattern == 2'h0) ? 6 : (i_pattern == 2'h1) ? 14 : 28;
	end

	// Word launched after the edge, bit 0 first; a gap inverts the lane data on every cycle
	always @(posedge i_mclk)
	begin
		logic [30:0] h;
		h = hist;
		if (i_send)
		begin
			for (int i = 0; i < 32; i++)
			begin
				word[i] = h[tap_a-1] ^ h[tap_b-1];
				h = {h[29:0], word[i]};
			end
			hist <= h;
			for (int l = 0; l < LANES; l++)
				o_lane_data[l*32+:32] <= word ^ {31'h0, i_err_lane[l]}; // Line error, history stays clean
			o_lane_valid <= '1;
		end
		else
		begin
			o_lane_data <= ~o_lane_data;
			o_lane_valid <= '0;
		end
	end
endmodule // lpst_prbs_source

// ---- verification/tb_top.sv ----
// Register-level testbench of the lane test block
`include "lpst_params.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// ----
	// Signals
	// ----
	localparam int REQ_BASE = (`LPST_REQ_FRAMES + `LPST_REQ_OCTETS + 3) / `LPST_OCTETS_PER_PCLK;
	logic         i_mclk = 1'b0;
	logic         i_rst = 1'b1;
	logic [11:0]  i_reg_addr = 12'h000;
	logic         i_reg_wr = 1'b0;
	logic         i_reg_rd = 1'b0;
	logic [7:0]   i_reg_wdata = 8'h00;
	logic [7:0]   o_reg_rdata;
	logic         o_reg_rvalid;
	logic         i_sync_request = 1'b0;
	logic         i_sync_error = 1'b0;
	logic         i_lmfc_pulse = 1'b0;
	logic [255:0] lane_data;
	logic [7:0]   lane_valid;
	logic         o_sync_request_out_n;
	logic         send = 1'b0;
	logic [1:0]   pattern = 2'h0;
	logic [7:0]   err_lane = 8'h00;
	logic         run_v = 1'b0;
	logic [7:0]   rv;
	logic [23:0]  cv;
	int           n_mismatch = 0;
	int           comparisons = 0;
	int           cycles = 0;

	lpst_top i_lpst_top (.i_mclk(i_mclk), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
		.i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
		.i_sync_request(i_sync_request), .i_sync_error(i_sync_error), .i_lmfc_pulse(i_lmfc_pulse),
		.i_lane_data(lane_data), .i_lane_valid(lane_valid), .o_sync_request_out_n(o_sync_request_out_n));
	lpst_prbs_source i_lpst_prbs_source (.i_mclk(i_mclk), .i_send(send), .i_pattern(pattern),
		.i_err_lane(err_lane), .o_lane_data(lane_data), .o_lane_valid(lane_valid));

	// Clock and hang guard
	always #5 i_mclk = ~i_mclk;
	always @(posedge i_mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			conclude();
		end
	end

	// ----
	// Tasks
	// ----
	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		comparisons++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(negedge i_mclk);
		i_reg_addr = a;
		i_reg_wdata = d;
		i_reg_wr = 1'b1;
		@(negedge i_mclk);
		i_reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		@(negedge i_mclk);
		i_reg_addr = a;
		i_reg_rd = 1'b1;
		@(negedge i_mclk);
		i_reg_rd = 1'b0;
		chk("read valid", 24'h1, {23'h0, o_reg_rvalid});
		d = o_reg_rdata;
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
		rd(a, rv);
		chk($sformatf("reg %h", a), {16'h0, e}, {16'h0, rv});
	endtask
	task automatic ctl(input logic [2:0] sel, input logic [1:0] pat, input logic run, input logic clr);
		run_v = run;
		wr(`LPST_OFF_TEST_CTRL, {1'b0, sel, pat, run, clr});
	endtask
	task automatic cnt(input logic [2:0] sel, input logic [23:0] e);
		ctl(sel, pattern, run_v, 1'b0);
		rd(`LPST_OFF_CNT_LOW, cv[7:0]);
		rd(`LPST_OFF_CNT_MID, cv[15:8]);
		rd(`LPST_OFF_CNT_HIGH, cv[23:16]);
		chk($sformatf("count lane %0d", sel), e, cv);
	endtask
	task automatic burst(input int n, input logic [7:0] m);
		for (int i = 0; i < n; i++)
		begin
			@(negedge i_mclk);
			send = 1'b1;
			err_lane = (i == 0) ? m : 8'h00;
		end
		@(negedge i_mclk);
		send = 1'b0;
		err_lane = 8'h00;
		repeat (3) @(negedge i_mclk);
	endtask
	task automatic low_time(input logic req, input int e, input string nm);
		int n;
		n = 0;
		@(negedge i_mclk);
		i_sync_request = req;
		i_sync_error = ~req;
		@(negedge i_mclk);
		i_sync_request = 1'b0;
		i_sync_error = 1'b0;
		while (o_sync_request_out_n === 1'b0 && n < 100)
		begin
			n++;
			@(negedge i_mclk);
		end
		chk(nm, 24'(e), 24'(n));
	endtask
	task automatic done(input string nm);
		$display("test %s done, mismatches %0d", nm, n_mismatch);
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ----
	// Tests
	// ----
	initial
	begin
		repeat (4) @(negedge i_mclk);
		i_rst = 1'b0;
		for (int a = 'h312; a <= 'h31e; a++)
			rdchk(12'(a), (a == 'h31d) ? 8'hff : 8'h00);
		done("reset");
		wr(`LPST_OFF_LMFC_PER, 8'h55);
		rdchk(`LPST_OFF_LMFC_PER, 8'h00);
		wr(12'h314, 8'h77);
		rdchk(12'h314, 8'h00);
		wr(`LPST_OFF_TEST_CTRL, 8'hff);
		rdchk(`LPST_OFF_TEST_CTRL, 8'h7f);
		for (int i = 0; i < 3; i++)
			wr(12'(`LPST_OFF_THR_LOW + i), 8'(8'ha0 + i));
		for (int i = 0; i < 3; i++)
			rdchk(12'(`LPST_OFF_THR_LOW + i), 8'(8'ha0 + i));
		done("access");
		for (int k = 0; k < 2; k++)
		begin
			wr(`LPST_OFF_SYNC_DUR, k ? 8'hf3 : 8'h00);
			low_time(1'b0, k ? 16 : 1, "error low");
			low_time(1'b1, REQ_BASE + (k ? 3 : 0), "request low");
		end
		done("sync");
		repeat (3)
		begin
			@(negedge i_mclk);
			i_lmfc_pulse = 1'b1;
			@(negedge i_mclk);
			i_lmfc_pulse = 1'b0;
			repeat (18) @(negedge i_mclk);
		end
		rdchk(`LPST_OFF_LMFC_PER, 8'h14);
		done("multiframe");
		wr(`LPST_OFF_TEST_EN, 8'hff);
		for (int p = 0; p < 4; p++)
		begin
			pattern = 2'(p);
			ctl(3'h2, pattern, 1'b1, 1'b1);
			ctl(3'h2, pattern, 1'b1, 1'b0);
			burst(4, 8'h00);
			repeat (p + 1) burst(2, 8'h04);
			burst(2, 8'h00);
			cnt(3'h2, 24'(3 * (p + 1)));
			cnt(3'h0, 24'h0);
		end
		done("patterns");
		pattern = 2'h0;
		wr(`LPST_OFF_THR_LOW, 8'h06);
		wr(`LPST_OFF_THR_MID, 8'h00);
		wr(`LPST_OFF_THR_HIGH, 8'h00);
		ctl(3'h2, pattern, 1'b1, 1'b1);
		ctl(3'h2, pattern, 1'b1, 1'b0);
		burst(4, 8'h00);
		repeat (2) burst(2, 8'h04);
		cnt(3'h2, 24'h6);
		rdchk(`LPST_OFF_PASS, 8'hff);
		burst(2, 8'h04);
		rdchk(`LPST_OFF_PASS, 8'hfb);
		ctl(3'h2, pattern, 1'b1, 1'b1);
		cnt(3'h2, 24'h0);
		rdchk(`LPST_OFF_PASS, 8'hff);
		done("threshold");
		wr(`LPST_OFF_TEST_EN, 8'hfb);
		burst(4, 8'h00);
		burst(2, 8'h04);
		cnt(3'h2, 24'h0);
		wr(`LPST_OFF_TEST_EN, 8'hff);
		ctl(3'h2, pattern, 1'b0, 1'b0);
		burst(4, 8'h00);
		burst(2, 8'h04);
		cnt(3'h2, 24'h0);
		done("gating");
		conclude();
	end
endmodule // tb_top
